//--- tpps_core.sv
// What this block does, and what its host must do
// (RULE1) ramp-down uses accel rate unless decel select is set
// (RULE2) host keeps decel above a fraction of accel
// (RULE3) leftover pulses go out at start speed
// (RULE4) enabled soft limits stop with decel outside range
// (RULE5) soft limit error clears back inside range
// (RULE6) soft limits ignored while homing
// (RULE7) auto home search after reset when enabled
// (RULE8) auto program start after reset when enabled
// (RULE9) program start waits for home search end
// (RULE10) host puts timer and home commands in program
// (RULE11) host stops motion before changing modes or settings
// (RULE12) multiplier 1..500, speeds 1..8000, scaled by multiplier
// (RULE13) accel is setting x 125 x multiplier
// (RULE14) decel is setting x 125 x multiplier
// (RULE15) ramped moves begin and end at start speed
// (RULE16) ramp only when drive speed exceeds start speed
// (RULE17) same ramp choice for home search high speed
// (RULE18) four drive speeds, one chosen per move
// (RULE19) ramp down when remaining pulses equal braking run
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "tpps_defines.svh"

module tpps_core #(
   parameter logic AUTO_HOME_DEF = 1'b0,
   parameter logic AUTO_PROG_DEF = 1'b0,
   parameter logic HOME_DIR      = 1'b1
) (
   // clock, reset, enable
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_ce,
   // register port
   input  wire logic [4:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   // pins
   input  wire logic        i_near_home,
   output logic             o_pulse,
   output logic             o_dir,
   output logic             o_busy,
   output logic             o_homing,
   output logic             o_prog_start,
   output logic             o_irq
);

   // ------------------------------------------------------------
   // settings clamp
   // ------------------------------------------------------------
   function automatic logic [12:0] clamp(input logic [31:0] d,
                                         input logic [12:0] mx);
      logic [12:0] r;
      r = d[12:0];
      if (d == 32'h0)
         r = 13'h0001;
      else if (d > {19'h0, mx})
         r = mx;
      return r;
   endfunction

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   tpps_pkg::tpps_mode_t mode, next_mode;
   logic [8:0]  mult, next_mult;
   logic [12:0] acc_set, next_acc_set;
   logic [12:0] dec_set, next_dec_set;
   logic [12:0] sv, next_sv;
   logic [12:0] drv [0:3];
   logic [12:0] next_drv [0:3];
   logic [12:0] home_hi, next_home_hi;
   logic [31:0] lim_pos, next_lim_pos;
   logic [31:0] lim_neg, next_lim_neg;
   logic [31:0] count, next_count;
   logic [2:0]  irq_stat, next_irq_stat;
   logic [2:0]  irq_en, next_irq_en;
   logic [31:0] next_rdata;

   // motion state, declared here for the read mux
   tpps_pkg::tpps_state_t state, next_state;
   tpps_pkg::tpps_boot_t  boot, next_boot;
   tpps_pkg::tpps_evt_t   evt;
   logic [12:0] v, next_v;
   logic [31:0] pos, next_pos;
   logic        lerr_p, next_lerr_p;
   logic        lerr_n, next_lerr_n;

   tpps_pkg::tpps_cmd_t cmd;
   logic wr_cmd;
   assign cmd    = tpps_pkg::tpps_cmd_t'(i_wdata[6:0]);
   assign wr_cmd = i_wr && (i_addr == `TPPS_A_CMD);

   // writes clamp each setting into its legal range
   always_comb begin
      next_mode     = mode;
      next_mult     = mult;
      next_acc_set  = acc_set;
      next_dec_set  = dec_set;
      next_sv       = sv;
      next_drv      = drv;
      next_home_hi  = home_hi;
      next_lim_pos  = lim_pos;
      next_lim_neg  = lim_neg;
      next_count    = count;
      next_irq_en   = irq_en;
      next_irq_stat = irq_stat;
      next_rdata    = 32'h0;
      if (i_wr) begin
         case (i_addr)
            `TPPS_A_MODE:    next_mode = i_wdata[3:0];
            `TPPS_A_MULT:
               next_mult = 9'(clamp(i_wdata, `TPPS_MULT_MAX)); // RULE12
            `TPPS_A_ACCEL:
               next_acc_set = clamp(i_wdata, `TPPS_SET_MAX); // RULE12
            `TPPS_A_DECEL:   next_dec_set = clamp(i_wdata, `TPPS_SET_MAX);
            `TPPS_A_START:   next_sv = clamp(i_wdata, `TPPS_SET_MAX);
            `TPPS_A_HOME_HI: next_home_hi = clamp(i_wdata, `TPPS_SET_MAX);
            `TPPS_A_LIM_POS: next_lim_pos = i_wdata;
            `TPPS_A_LIM_NEG: next_lim_neg = i_wdata;
            `TPPS_A_COUNT:   next_count = i_wdata;
            `TPPS_A_IRQ_EN:  next_irq_en = i_wdata[2:0];
            default: begin
               if (i_addr >= `TPPS_A_DRV0 && i_addr < `TPPS_A_HOME_HI)
                  next_drv[i_addr[1:0] - 2'h1] =
                     clamp(i_wdata, `TPPS_SET_MAX); // RULE18
            end
         endcase
      end
      // a new event beats a clear in the same cycle
      if (i_wr && i_addr == `TPPS_A_IRQ_CLR)
         next_irq_stat = irq_stat & ~i_wdata[2:0];
      next_irq_stat = next_irq_stat | evt;
      if (i_rd) begin
         case (i_addr)
            `TPPS_A_MODE:     next_rdata = {28'h0, mode};
            `TPPS_A_MULT:     next_rdata = {23'h0, mult};
            `TPPS_A_ACCEL:    next_rdata = {19'h0, acc_set};
            `TPPS_A_DECEL:    next_rdata = {19'h0, dec_set};
            `TPPS_A_START:    next_rdata = {19'h0, sv};
            `TPPS_A_HOME_HI:  next_rdata = {19'h0, home_hi};
            `TPPS_A_LIM_POS:  next_rdata = lim_pos;
            `TPPS_A_LIM_NEG:  next_rdata = lim_neg;
            `TPPS_A_COUNT:    next_rdata = count;
            `TPPS_A_POS:      next_rdata = pos;
            `TPPS_A_STATUS:   next_rdata = {25'h0, boot == tpps_pkg::TPPS_B_DONE,
                                 lerr_n, lerr_p, o_homing, state, o_busy};
            `TPPS_A_SPEED:    next_rdata = {19'h0, v};
            `TPPS_A_IRQ_STAT: next_rdata = {29'h0, irq_stat};
            `TPPS_A_IRQ_EN:   next_rdata = {29'h0, irq_en};
            default: begin
               if (i_addr >= `TPPS_A_DRV0 && i_addr < `TPPS_A_HOME_HI)
                  next_rdata = {19'h0, drv[i_addr[1:0] - 2'h1]};
            end
         endcase
      end
   end

   // auto-start bits reset to the stored power-on choice
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         mode     <= {AUTO_PROG_DEF, AUTO_HOME_DEF, 2'h0};
         mult     <= `TPPS_MULT_RST;
         acc_set  <= `TPPS_ACCEL_RST;
         dec_set  <= `TPPS_DECEL_RST;
         sv       <= `TPPS_START_RST;
         drv[0]   <= `TPPS_DRV0_RST;
         drv[1]   <= `TPPS_DRV1_RST;
         drv[2]   <= `TPPS_DRV2_RST;
         drv[3]   <= `TPPS_DRV3_RST;
         home_hi  <= `TPPS_HOME_HI_RST;
         lim_pos  <= `TPPS_LIM_POS_RST;
         lim_neg  <= `TPPS_LIM_NEG_RST;
         count    <= `TPPS_COUNT_RST;
         irq_stat <= 3'h0;
         irq_en   <= 3'h0;
         o_rdata  <= 32'h0;
      end else if (i_ce) begin
         mode     <= next_mode;
         mult     <= next_mult;
         acc_set  <= next_acc_set;
         dec_set  <= next_dec_set;
         sv       <= next_sv;
         drv      <= next_drv;
         home_hi  <= next_home_hi;
         lim_pos  <= next_lim_pos;
         lim_neg  <= next_lim_neg;
         count    <= next_count;
         irq_stat <= next_irq_stat;
         irq_en   <= next_irq_en;
         o_rdata  <= next_rdata;
      end
   end

   assign o_irq = |(irq_stat & irq_en);

   // ------------------------------------------------------------
   // near-home pin synchroniser
   // ------------------------------------------------------------
   logic nh_meta;
   logic nh_sync;
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         nh_meta <= 1'b0;
         nh_sync <= 1'b0;
      end else if (i_ce) begin
         nh_meta <= i_near_home;
         nh_sync <= nh_meta;
      end
   end

   // --------------------
   // motion generator
   // --------------------
   logic [24:0] pacc, next_pacc;
   logic [24:0] vacc, next_vacc;
   logic [31:0] rem, next_rem;
   logic [12:0] tgt, next_tgt;
   logic        dir, next_dir;
   logic        cont, next_cont;
   logic        homing, next_homing;
   logic        halt, next_halt;
   logic        next_pulse;
   logic        next_prog;

   logic [21:0] pps;
   logic [12:0] dn_rate;
   logic [63:0] need_k;
   logic [63:0] have_k;
   logic        near_end;
   logic        out_p;
   logic        out_n;
   logic        viol;
   logic        stop_req;
   logic        start_go;
   logic        boot_go;
   logic        done;
   logic [24:0] psum;
   logic [24:0] vsum;

   // fixed pps from setting units; the fraction lives in the accumulator
   assign pps     = 22'(v) * 22'(mult); // RULE15 RULE18
   assign dn_rate = mode.decel_sel ? dec_set : acc_set; // RULE1 RULE14
   assign need_k  = (64'(v) * 64'(v) - 64'(sv) * 64'(sv)) * 64'(mult);
   assign have_k  = 64'(rem) * 64'(dn_rate) * `TPPS_DEC_K;
   // slow down once remaining pulses no longer exceed the braking run
   assign near_end = !cont && (v > sv) && (have_k <= need_k); // RULE19
   assign out_p   = $signed(pos) > $signed(lim_pos);
   assign out_n   = $signed(pos) < $signed(lim_neg);
   assign viol    = mode.swlim_en && !homing && o_busy
                    && ((!dir && out_p) || (dir && out_n)); // RULE4 RULE6
   assign stop_req = (wr_cmd && cmd.stop) || viol
                     || (homing && nh_sync);
   assign boot_go  = (boot == tpps_pkg::TPPS_B_START) && mode.auto_home;
   assign start_go = state == tpps_pkg::TPPS_IDLE
                     && (boot_go || (wr_cmd && cmd.start && !cmd.stop));

   always_comb begin
      next_state  = state;
      next_boot   = boot;
      next_v      = v;
      next_pos    = pos;
      next_pacc   = pacc;
      next_vacc   = vacc;
      next_rem    = rem;
      next_tgt    = tgt;
      next_dir    = dir;
      next_cont   = cont;
      next_homing = homing;
      next_halt   = halt || (stop_req && state != tpps_pkg::TPPS_IDLE);
      next_lerr_p = lerr_p;
      next_lerr_n = lerr_n;
      next_pulse  = 1'b0;
      next_prog   = 1'b0;
      evt         = '0;
      done        = 1'b0;
      psum        = pacc + 25'(pps);
      vsum        = 25'h0;
      // error flags: set on a violation, cleared back inside the range
      if (viol) begin
         next_lerr_p = lerr_p || !dir; // RULE4
         next_lerr_n = lerr_n || dir;
         evt.lim_err = !(lerr_p || lerr_n);
      end else begin
         if (!out_p) next_lerr_p = 1'b0; // RULE5
         if (!out_n) next_lerr_n = 1'b0; // RULE5
      end
      // preset of the position counter only while idle
      if (i_wr && i_addr == `TPPS_A_POS && state == tpps_pkg::TPPS_IDLE)
         next_pos = i_wdata;
      // pulse phase accumulator, held when no pulses remain
      if (state != tpps_pkg::TPPS_IDLE && (cont || rem != 32'h0)) begin
         if (psum >= `TPPS_FCLK_HZ) begin
            next_pacc  = psum - `TPPS_FCLK_HZ;
            next_pulse = 1'b1;
            next_rem   = rem - 32'h1;
            next_pos   = dir ? pos - 32'h1 : pos + 32'h1;
         end else begin
            next_pacc = psum;
         end
      end
      case (state)
         tpps_pkg::TPPS_IDLE: begin
            if (start_go) begin
               next_dir    = boot_go ? HOME_DIR : cmd.dir;
               next_cont   = boot_go || cmd.cont || cmd.home;
               next_homing = boot_go || cmd.home;
               next_tgt    = (boot_go || cmd.home) ? home_hi : drv[cmd.sel];
               next_rem    = count;
               next_pacc   = 25'h0;
               next_vacc   = 25'h0;
               next_halt   = 1'b0;
               // ramp only when the plateau is above start speed
               if (next_tgt > sv) begin // RULE16 RULE17
                  next_v     = sv; // RULE15
                  next_state = tpps_pkg::TPPS_ACCEL;
               end else begin
                  next_v     = next_tgt;
                  next_state = tpps_pkg::TPPS_CRUISE;
               end
            end
         end
         tpps_pkg::TPPS_ACCEL: begin
            if (!cont && rem == 32'h0) begin
               done = 1'b1;
            end else if (stop_req || halt || near_end) begin
               next_state = tpps_pkg::TPPS_DECEL;
            end else begin
               vsum = vacc + 25'(acc_set * `TPPS_ACC_SCALE); // RULE13
               if (vsum >= `TPPS_FCLK_HZ) begin
                  next_vacc = vsum - `TPPS_FCLK_HZ;
                  next_v    = v + 13'h0001;
               end else begin
                  next_vacc = vsum;
               end
               if (next_v >= tgt) begin
                  next_v     = tgt;
                  next_state = tpps_pkg::TPPS_CRUISE;
               end
            end
         end
         tpps_pkg::TPPS_CRUISE: begin
            if (!cont && rem == 32'h0)
               done = 1'b1;
            else if (stop_req && tgt <= sv)
               done = 1'b1; // constant speed stops at once
            else if (stop_req || near_end)
               next_state = tpps_pkg::TPPS_DECEL;
         end
         tpps_pkg::TPPS_DECEL: begin
            if (!cont && rem == 32'h0) begin // RULE3
               done = 1'b1;
            end else if (v > sv) begin
               vsum = vacc + 25'(dn_rate * `TPPS_ACC_SCALE); // RULE14
               if (vsum >= `TPPS_FCLK_HZ) begin
                  next_vacc = vsum - `TPPS_FCLK_HZ;
                  next_v    = v - 13'h0001;
               end else begin
                  next_vacc = vsum;
               end
            end else if (cont || halt) begin
               done = 1'b1; // RULE15
            end
            // otherwise creep out the rest at start speed
         end
         default: next_state = tpps_pkg::TPPS_IDLE;
      endcase
      if (done) begin
         next_pulse     = 1'b0; // no step after busy drops
         next_pos       = pos;
         next_state     = tpps_pkg::TPPS_IDLE;
         next_v         = 13'h0;
         next_homing    = 1'b0;
         evt.move_done  = 1'b1;
         evt.home_done  = homing;
      end
      // power-up: home first, then the stored program
      case (boot)
         tpps_pkg::TPPS_B_START: begin
            if (mode.auto_home) begin // RULE7
               next_boot = tpps_pkg::TPPS_B_HOME;
            end else begin
               next_prog = mode.auto_prog; // RULE8
               next_boot = tpps_pkg::TPPS_B_DONE;
            end
         end
         tpps_pkg::TPPS_B_HOME: begin
            if (done) begin
               next_prog = mode.auto_prog; // RULE9
               next_boot = tpps_pkg::TPPS_B_DONE;
            end
         end
         tpps_pkg::TPPS_B_DONE: next_boot = boot;
         default: next_boot = tpps_pkg::TPPS_B_DONE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state        <= tpps_pkg::TPPS_IDLE;
         boot         <= tpps_pkg::TPPS_B_START;
         v            <= 13'h0;
         pos          <= 32'h0;
         pacc         <= 25'h0;
         vacc         <= 25'h0;
         rem          <= 32'h0;
         tgt          <= 13'h0;
         dir          <= 1'b0;
         cont         <= 1'b0;
         homing       <= 1'b0;
         halt         <= 1'b0;
         lerr_p       <= 1'b0;
         lerr_n       <= 1'b0;
         o_pulse      <= 1'b0;
         o_prog_start <= 1'b0;
      end else if (i_ce) begin
         state        <= next_state;
         boot         <= next_boot;
         v            <= next_v;
         pos          <= next_pos;
         pacc         <= next_pacc;
         vacc         <= next_vacc;
         rem          <= next_rem;
         tgt          <= next_tgt;
         dir          <= next_dir;
         cont         <= next_cont;
         homing       <= next_homing;
         halt         <= next_halt;
         lerr_p       <= next_lerr_p;
         lerr_n       <= next_lerr_n;
         o_pulse      <= next_pulse;
         o_prog_start <= next_prog;
      end
   end

   assign o_dir    = dir;
   assign o_busy   = state != tpps_pkg::TPPS_IDLE;
   assign o_homing = homing;

endmodule

//--- tpps_core_assertions.sv
`timescale 1ns/1ps
`include "tpps_defines.svh"

module tpps_core_chk #(
   parameter logic AUTO_HOME_DEF = 1'b0
) (
   // clock, reset, enable
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic        i_ce,
   // register port
   input wire logic [4:0]  i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   // pins
   input wire logic        o_pulse,
   input wire logic        o_busy,
   input wire logic        o_homing,
   input wire logic        o_prog_start,
   input wire logic        o_irq
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);

   // --------------------
   // bus and pin relations
   // --------------------
   // read data stands one cycle only
   chk_rdata_idle: assert property (
      i_ce && !i_rd |=> o_rdata == 32'h0)
      else $error("read data outside its slot");
   chk_pulse_busy: assert property (
      o_pulse |-> o_busy)
      else $error("pulse while idle");
   chk_pulse_single: assert property (
      o_pulse |=> !o_pulse)
      else $error("pulse wider than one cycle");
   chk_start_busy: assert property (
      i_ce && i_wr && i_addr == `TPPS_A_CMD && i_wdata[0]
      && !i_wdata[6] && !o_busy |=> o_busy)
      else $error("start while idle not taken");
   chk_prog_single: assert property (
      o_prog_start |=> !o_prog_start)
      else $error("program start wider than one cycle");
   chk_prog_idle: assert property (
      o_prog_start |-> !o_busy && !o_homing)
      else $error("program start during motion");
   // boot sequencer latency is short and fixed
   chk_auto_home: assert property (
      AUTO_HOME_DEF && $fell(i_rst) |-> ##[0:4] o_homing)
      else $error("no home search after reset");
   chk_homing_busy: assert property (
      o_homing |-> o_busy)
      else $error("homing without motion");
   chk_irq_masked: assert property (
      i_ce && i_wr && i_addr == `TPPS_A_IRQ_EN
      && i_wdata[2:0] == 3'h0 |=> !o_irq)
      else $error("interrupt with all sources masked");

   // main scenarios reached
   cover property (o_prog_start);
   cover property (o_homing ##1 !o_homing);
   cover property (o_pulse ##1 !o_busy);
endmodule

bind tpps_core tpps_core_chk #(.AUTO_HOME_DEF(AUTO_HOME_DEF)) i_chk (
   .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_pulse(o_pulse), .o_busy(o_busy), .o_homing(o_homing),
   .o_prog_start(o_prog_start), .o_irq(o_irq)
);

//--- tpps_defines.svh
`ifndef TPPS_DEFINES_SVH
`define TPPS_DEFINES_SVH

// --------------------
// clock rate and rate scaling
// --------------------
`define TPPS_FCLK_HZ      25'h17D7840
`define TPPS_ACC_SCALE    20'h0007D
`define TPPS_DEC_K        64'h00000000000000FA

// --------------------
// register word addresses
// --------------------
`define TPPS_A_MODE       5'h00
`define TPPS_A_MULT       5'h01
`define TPPS_A_ACCEL      5'h02
`define TPPS_A_DECEL      5'h03
`define TPPS_A_START      5'h04
`define TPPS_A_DRV0       5'h05
`define TPPS_A_HOME_HI    5'h09
`define TPPS_A_LIM_POS    5'h0A
`define TPPS_A_LIM_NEG    5'h0B
`define TPPS_A_COUNT      5'h0C
`define TPPS_A_CMD        5'h0D
`define TPPS_A_POS        5'h0E
`define TPPS_A_STATUS     5'h0F
`define TPPS_A_SPEED      5'h10
`define TPPS_A_IRQ_STAT   5'h11
`define TPPS_A_IRQ_CLR    5'h12
`define TPPS_A_IRQ_EN     5'h13

// --------------------
// reset values and setting limits
// --------------------
`define TPPS_MULT_RST     9'h00A
`define TPPS_MULT_MAX     13'h01F4
`define TPPS_SET_MAX      13'h1F40
`define TPPS_ACCEL_RST    13'h0190
`define TPPS_DECEL_RST    13'h0190
`define TPPS_START_RST    13'h0032
`define TPPS_DRV0_RST     13'h000A
`define TPPS_DRV1_RST     13'h0064
`define TPPS_DRV2_RST     13'h03E8
`define TPPS_DRV3_RST     13'h1F40
`define TPPS_HOME_HI_RST  13'h03E8
`define TPPS_LIM_POS_RST  32'h007FFFFF
`define TPPS_LIM_NEG_RST  32'hFF800000
`define TPPS_COUNT_RST    32'h00000000

`endif

//--- tpps_motor_model.sv
`timescale 1ns/1ps

module tpps_motor_model (
   // clock, reset, statistics clear
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_clear,
   // pulse train and sensor mark
   input  wire logic        i_pulse,
   input  wire logic        i_dir,
   input  wire logic [31:0] i_home_mark,
   // sensor and measurements
   output logic             o_near_home,
   output logic [31:0]      o_pos,
   output logic [31:0]      o_count,
   output logic [31:0]      o_first_gap,
   output logic [31:0]      o_min_gap,
   output logic [31:0]      o_last_gap
);
   logic [31:0] gap;

   // sensor closes at or below the mark
   assign o_near_home = $signed(o_pos) <= $signed(i_home_mark);

   // one step per pulse, dir 1 is minus
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_pos <= 32'h0;
      end else if (i_pulse) begin
         o_pos <= i_dir ? o_pos - 32'h1 : o_pos + 32'h1;
      end
   end

   // step spacing; first gap kept out of the minimum
   always_ff @(posedge i_clk) begin
      if (i_clear) begin
         o_count     <= 32'h0;
         gap         <= 32'h1;
         o_first_gap <= 32'h0;
         o_last_gap  <= 32'h0;
         o_min_gap   <= 32'hFFFFFFFF;
      end else if (i_pulse) begin
         o_count    <= o_count + 32'h1;
         gap        <= 32'h1;
         o_last_gap <= gap;
         if (o_count == 32'h0) begin
            o_first_gap <= gap;
         end else if (gap < o_min_gap) begin
            o_min_gap <= gap;
         end
      end else begin
         gap <= gap + 32'h1;
      end
   end
endmodule

//--- tpps_pkg.sv
package tpps_pkg;

   // motion state, gray along idle-accel-cruise-decel
   typedef enum logic [1:0] {
      TPPS_IDLE   = 2'h0,
      TPPS_ACCEL  = 2'h1,
      TPPS_CRUISE = 2'h3,
      TPPS_DECEL  = 2'h2
   } tpps_state_t;

   // power-up sequencing
   typedef enum logic [1:0] {
      TPPS_B_START = 2'h0,
      TPPS_B_HOME  = 2'h1,
      TPPS_B_DONE  = 2'h3
   } tpps_boot_t;

   typedef struct packed {
      logic auto_prog;
      logic auto_home;
      logic swlim_en;
      logic decel_sel;
   } tpps_mode_t;

   typedef struct packed {
      logic       stop;
      logic       home;
      logic       cont;
      logic       dir;
      logic [1:0] sel;
      logic       start;
   } tpps_cmd_t;

   typedef struct packed {
      logic home_done;
      logic lim_err;
      logic move_done;
   } tpps_evt_t;

endpackage

//--- trapezoidal_pulse_profile_setup_bench.sv
`timescale 1ns/1ps

module trapezoidal_pulse_profile_setup_bench;
   typedef struct {
      logic [4:0]  a;
      logic        w;
      logic [31:0] d;
      logic [31:0] e;
   } tpps_row_t;

   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic [4:0]  i_addr = 5'h00;
   logic [31:0] i_wdata = 32'h0;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic        clr = 1'b1;
   logic [31:0] mark = 32'h0;
   logic [31:0] o_rdata, pos, cnt, fg, mg, lg, v, p0;
   logic        o_pulse, o_dir, o_busy, o_homing, o_prog_start, o_irq;
   logic        near, hm;
   int          bad_count = 0;
   int          compares = 0;
   int          ta, tb, k;
   tpps_row_t   rows [19] = '{
      '{5'h00,1'b0,32'h0,32'hC},     '{5'h01,1'b0,32'h0,32'hA},
      '{5'h02,1'b0,32'h0,32'h190},   '{5'h03,1'b0,32'h0,32'h190},
      '{5'h04,1'b0,32'h0,32'h32},    '{5'h05,1'b0,32'h0,32'hA},
      '{5'h06,1'b0,32'h0,32'h64},    '{5'h07,1'b0,32'h0,32'h3E8},
      '{5'h08,1'b0,32'h0,32'h1F40},  '{5'h09,1'b0,32'h0,32'h3E8},
      '{5'h0A,1'b0,32'h0,32'h7FFFFF},'{5'h0B,1'b0,32'h0,32'hFF800000},
      '{5'h1F,1'b0,32'h0,32'h0},     '{5'h12,1'b0,32'h0,32'h0},
      '{5'h01,1'b1,32'h0,32'h1},     '{5'h01,1'b1,32'h1FF,32'h1F4},
      '{5'h02,1'b1,32'h2000,32'h1F40},'{5'h04,1'b1,32'h0,32'h1},
      '{5'h1F,1'b1,32'h5,32'h0}};

   tpps_core #(.AUTO_HOME_DEF(1'b1), .AUTO_PROG_DEF(1'b1)) i_dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_near_home(near), .o_pulse(o_pulse), .o_dir(o_dir),
      .o_busy(o_busy), .o_homing(o_homing),
      .o_prog_start(o_prog_start), .o_irq(o_irq));

   tpps_motor_model i_motor (
      .i_clk(i_clk), .i_rst(i_rst), .i_clear(clr), .i_pulse(o_pulse),
      .i_dir(o_dir), .i_home_mark(mark), .o_near_home(near),
      .o_pos(pos), .o_count(cnt), .o_first_gap(fg), .o_min_gap(mg),
      .o_last_gap(lg));

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   // an unknown value fails at the low bound
   task automatic rng(input logic [31:0] x, lo, hi);
      chk(x, (x >= lo && x <= hi) === 1'b1 ? x : lo);
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_clk);
      i_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      @(negedge i_clk);
      d = o_rdata;
   endtask

   // stats cleared around the start write
   task automatic mv(input logic [31:0] n, input logic [31:0] c);
      wr(5'h0C, n);
      clr <= 1'b1;
      wr(5'h0D, c);
      clr <= 1'b0;
   endtask

   task automatic idle(output int t);
      @(negedge i_clk);
      for (t = 0; o_busy !== 1'b0; t++) @(negedge i_clk);
   endtask

   task automatic print_verdict();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial forever #20 i_clk = ~i_clk;

   initial begin
      repeat (90000) @(posedge i_clk);
      bad_count++;
      print_verdict();
   end

   // --------------------
   // main sequence
   // --------------------
   initial begin
      hm = 1'b0;
      repeat (8) @(posedge i_clk);
      i_rst <= 1'b0;
      // sensor closed: boot homing ends at once
      for (k = 0; k < 200 && o_prog_start !== 1'b1; k++) begin
         @(negedge i_clk);
         if (o_homing === 1'b1) hm = 1'b1;
      end
      chk(32'(hm), 32'h1);
      chk(32'(o_prog_start), 32'h1);
      rd(5'h11, v);
      chk(32'(v[2]), 32'h1);
      mark <= 32'h80000000;
      foreach (rows[k]) begin
         if (rows[k].w) wr(rows[k].a, rows[k].d);
         rd(rows[k].a, v);
         chk(v, rows[k].e);
      end
      wr(5'h13, 32'h7);
      @(negedge i_clk);
      chk(32'(o_irq), 32'h1);
      wr(5'h13, 32'h0);
      @(negedge i_clk);
      chk(32'(o_irq), 32'h0);
      wr(5'h13, 32'h7);
      wr(5'h04, 32'h64);
      wr(5'h07, 32'h190);
      wr(5'h05, 32'h32);
      // symmetric ramp: speed grows one unit per 25 cycles
      mv(32'd100, 32'h05);
      repeat (2500) @(negedge i_clk);
      rd(5'h10, v);
      rng(v, 32'd197, 32'd202);
      idle(ta);
      ta = ta + 2503;
      chk(cnt, 32'd100);
      rng(fg, 32'd400, 32'd505);
      rng(mg, 32'd124, 32'd130);
      rng(lg, 32'd400, 32'd520);
      // slower decel stretches the move
      wr(5'h03, 32'h7D0);
      wr(5'h00, 32'hD);
      mv(32'd100, 32'h05);
      idle(tb);
      chk(cnt, 32'd100);
      rng(tb, ta + 3000, 32'd70000);
      rng(lg, 32'd400, 32'd520);
      // drive below start speed runs flat
      wr(5'h00, 32'hC);
      mv(32'd5, 32'h01);
      idle(k);
      chk(cnt, 32'd5);
      rng(fg, 32'd990, 32'd1010);
      rng(mg, 32'd990, 32'd1010);
      // soft limit trip, then back inside
      p0 = pos;
      wr(5'h0A, p0 + 32'd20);
      wr(5'h00, 32'hE);
      wr(5'h12, 32'h7);
      mv(32'd0, 32'h15);
      idle(k);
      rng(pos, p0 + 32'd21, p0 + 32'd60);
      rd(5'h0F, v);
      chk(32'(v[4]), 32'h1);
      chk(32'(o_irq), 32'h1);
      rd(5'h0E, v);
      chk(v, pos);
      wr(5'h12, 32'h7);
      @(negedge i_clk);
      chk(32'(o_irq), 32'h0);
      mv(pos - p0 - 32'd10, 32'h0D);
      idle(k);
      chk(pos, p0 + 32'd10);
      rd(5'h0F, v);
      chk(32'(v[4]), 32'h0);
      print_verdict();
   end
endmodule
